/* logic/ioecfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ioecfg_top (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   input wire logic [5:0] link_up_in,
   input wire logic [5:0] link_act_in,
   input wire logic smb_clk_in,
   input wire logic eeprom_done_in,
   output logic cmd_valid_out,
   output ioecfg_pkg::ioecfg_cmd_type cmd_out,
   input wire logic cmd_ready_in,
   input wire logic rsp_done_in,
   input wire logic [7:0] rsp_data_in
);
   // ----------------------------------------
   // resets and crossings
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   logic [1:0] lrst_sync;
   logic lrst_n;
   logic ee_meta, ee_done;
   logic ack_meta, ack_s1, ack_s2, ack_edge;
   logic req_meta, req_s1, req_s2, req_edge;
   logic req_tgl, ack_tgl;
   assign rst_n = rst_sync[1];
   assign lrst_n = lrst_sync[1];
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
      if (!arst_n_in)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   always_ff @(posedge smb_clk_in or negedge arst_n_in)
      if (!arst_n_in)
         lrst_sync <= 2'h0;
      else
         lrst_sync <= {lrst_sync[0], 1'b1};
   always_ff @(posedge ref_clk_in or negedge rst_n)
      if (!rst_n)
      begin
         {ee_meta, ee_done, ack_meta, ack_s1, ack_s2} <= 5'h00;
      end
      else
      begin
         ee_meta <= eeprom_done_in;
         ee_done <= ee_meta;
         ack_meta <= ack_tgl;
         ack_s1 <= ack_meta;
         ack_s2 <= ack_s1;
      end
   assign ack_edge = ack_s1 ^ ack_s2;
   always_ff @(posedge smb_clk_in or negedge lrst_n)
      if (!lrst_n)
         {req_meta, req_s1, req_s2} <= 3'h0;
      else
         {req_meta, req_s1, req_s2} <= {req_tgl, req_meta, req_s1};
   assign req_edge = req_s1 ^ req_s2;

   // ----------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic [31:0] addr_first, next_addr_first;
   logic [6:0] addr_second, next_addr_second;
   logic [23:0] slot_ctl, next_slot_ctl;
   logic [5:0] hp_cfg, next_hp_cfg;
   logic [4:0] pending, next_pending, pend_clr;
   logic [15:0] capture [ioecfg_pkg::NUM_EXP];
   logic [15:0] next_capture [ioecfg_pkg::NUM_EXP];
   logic cap_we;
   ioecfg_pkg::ioecfg_seq_type state, next_state;
   logic [2:0] cur_exp, next_exp, step, next_step;
   ioecfg_pkg::ioecfg_cmd_type cmd, next_cmd;
   logic next_req;
   logic [7:0] lrdata;
   logic acc;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign acc = hsel_in && hready_in && htrans_in[1] && hsize_in == 3'h2;

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      int unsigned i;
      reg_read = 32'h00000000;
      unique case (a)
         ioecfg_pkg::OFS_ADDR_FIRST: reg_read = addr_first;
         ioecfg_pkg::OFS_ADDR_SECOND: reg_read = {25'h0, addr_second};
         ioecfg_pkg::OFS_SLOT_CTL: reg_read = {8'h00, slot_ctl};
         ioecfg_pkg::OFS_HP_CFG: reg_read = {26'h0, hp_cfg};
         ioecfg_pkg::OFS_STATUS:
            reg_read = {19'h0, pending, 6'h0, ee_done, state != ioecfg_pkg::SEQ_IDLE};
         default:
            for (i = 0; i < ioecfg_pkg::NUM_EXP; i++)
               if (a == ioecfg_pkg::OFS_CAPTURE + 8'(4 * i))
                  reg_read = {16'h0000, capture[i]};
      endcase
   endfunction

   always_comb
   begin
      next_wr_pend = acc && hwrite_in;
      next_wr_addr = acc ? haddr_in[7:0] : wr_addr;
      next_hrdata = (acc && !hwrite_in) ? reg_read(haddr_in[7:0]) : 32'h00000000;
      next_addr_first = addr_first;
      next_addr_second = addr_second;
      next_slot_ctl = slot_ctl;
      next_hp_cfg = hp_cfg;
      next_pending = pending & ~pend_clr;
      next_capture = capture;
      if (wr_pend)
      begin
         unique case (wr_addr)
            ioecfg_pkg::OFS_ADDR_FIRST:
            begin
               next_addr_first = hwdata_in & ioecfg_pkg::ADDR_FIELD_MASK;
               next_pending[3:0] = 4'hf;
            end
            ioecfg_pkg::OFS_ADDR_SECOND:
            begin
               next_addr_second = hwdata_in[6:0];
               next_pending[4] = 1'b1;
            end
            ioecfg_pkg::OFS_SLOT_CTL: next_slot_ctl = hwdata_in[23:0];
            ioecfg_pkg::OFS_HP_CFG: next_hp_cfg = hwdata_in[5:0];
            default: next_pending = pending & ~pend_clr | 5'h00;
         endcase
      end
      // read data returned in the data phase
      if (cap_we)
         next_capture[cur_exp][8 * cmd.reg_num[0] +: 8] = lrdata;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n)
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata_out <= 32'h00000000;
         addr_first <= ioecfg_pkg::ADDR_FIRST_RST;
         addr_second <= ioecfg_pkg::ADDR_SECOND_RST;
         slot_ctl <= ioecfg_pkg::SLOT_CTL_RST;
         hp_cfg <= ioecfg_pkg::HP_CFG_RST;
         pending <= 5'h00;
         for (int i = 0; i < ioecfg_pkg::NUM_EXP; i++)
            capture[i] <= 16'h0000;
      end
      else
      begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata_out <= next_hrdata;
         addr_first <= next_addr_first;
         addr_second <= next_addr_second;
         slot_ctl <= next_slot_ctl;
         hp_cfg <= next_hp_cfg;
         pending <= next_pending;
         capture <= next_capture;
      end

   // ----------------------------------------
   // configuration sequencer
   // ----------------------------------------
   // hot-plug section byte; low four pins stay inputs
   function automatic logic [7:0] hp_byte(input logic [3:0] ctl, input logic en);
      hp_byte = 8'h00;
      hp_byte[ioecfg_pkg::ATTN_BIT] = ~(en & ctl[0]);
      hp_byte[ioecfg_pkg::PIND_BIT] = ~(en & ctl[1]);
      hp_byte[ioecfg_pkg::PEN_BIT] = en & ctl[2];
      hp_byte[ioecfg_pkg::ILOCK_BIT] = en & ctl[3];
   endfunction

   function automatic logic [2:0] lowest(input logic [4:0] v);
      lowest = 3'h0;
      for (int i = ioecfg_pkg::NUM_EXP - 1; i >= 0; i--)
         if (v[i])
            lowest = 3'(i);
   endfunction

   logic [7:0] lo_out, hi_out, lo_dir, hi_dir, step_data;
   logic [6:0] exp_addr;
   logic skip;
   always_comb
   begin
      lo_out = 8'h00;
      hi_out = 8'h00;
      lo_dir = ioecfg_pkg::DIR_ALL_IN;
      hi_dir = ioecfg_pkg::DIR_ALL_IN;
      exp_addr = addr_second;
      skip = 1'b0;
      if (cur_exp < 3'h4)
         exp_addr = addr_first[8 * cur_exp[1:0] +: 7];
      // section map
      unique case (cur_exp)
         3'h0:
         begin
            lo_out = hp_byte(slot_ctl[11:8], hp_cfg[2]);
            hi_out = hp_byte(slot_ctl[19:16], hp_cfg[4]);
            lo_dir = ioecfg_pkg::DIR_HOTPLUG;
            hi_dir = ioecfg_pkg::DIR_HOTPLUG;
         end
         3'h1:
         begin
            lo_out = hp_byte(slot_ctl[15:12], hp_cfg[3]);
            hi_out = hp_byte(slot_ctl[23:20], hp_cfg[5]);
            lo_dir = ioecfg_pkg::DIR_HOTPLUG;
            hi_dir = ioecfg_pkg::DIR_HOTPLUG;
         end
         3'h2: skip = step == 3'h1;
         3'h3:
         begin
            hi_out = hp_byte(slot_ctl[7:4], hp_cfg[1]);
            hi_dir = ioecfg_pkg::DIR_HOTPLUG;
         end
         3'h4:
         begin
            // lit means low; disabled ports show link down
            lo_out = ioecfg_pkg::LED_UNUSED | {2'h0, ~(hp_cfg & link_up_in)};
            hi_out = ioecfg_pkg::LED_UNUSED | {2'h0, ~(hp_cfg & link_act_in)};
            lo_dir = ioecfg_pkg::DIR_ALL_OUT;
            hi_dir = ioecfg_pkg::DIR_ALL_OUT;
            skip = step > 3'h5;
         end
         default: skip = 1'b1;
      endcase
      unique case (step)
         3'h0: step_data = lo_out;
         3'h1: step_data = hi_out;
         3'h2, 3'h3: step_data = ioecfg_pkg::INV_NONE;
         3'h4: step_data = lo_dir;
         3'h5: step_data = hi_dir;
         default: step_data = 8'h00;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_exp = cur_exp;
      next_step = step;
      next_cmd = cmd;
      next_req = req_tgl;
      pend_clr = 5'h00;
      cap_we = 1'b0;
      unique case (state)
         ioecfg_pkg::SEQ_IDLE:
            if (ee_done && pending != 5'h00)
            begin
               next_exp = lowest(pending);
               pend_clr[lowest(pending)] = 1'b1;
               next_step = 3'h0;
               next_state = ioecfg_pkg::SEQ_ISSUE;
            end
         ioecfg_pkg::SEQ_ISSUE:
            if (!skip)
            begin
               next_cmd.addr = exp_addr;
               next_cmd.rd = step > 3'h5;
               // steps walk registers 2..7 then 0, 1
               next_cmd.reg_num = step + 3'h2;
               next_cmd.data = step_data;
               next_req = ~req_tgl;
               next_state = ioecfg_pkg::SEQ_WAIT;
            end
            else if (step == ioecfg_pkg::LAST_STEP)
               next_state = ioecfg_pkg::SEQ_IDLE;
            else
               next_step = step + 3'h1;
         ioecfg_pkg::SEQ_WAIT:
            if (ack_edge)
            begin
               cap_we = cmd.rd;
               // next expander only after the last step
               next_state = step == ioecfg_pkg::LAST_STEP ?
                  ioecfg_pkg::SEQ_IDLE : ioecfg_pkg::SEQ_ISSUE;
               next_step = step + 3'h1;
            end
         default: next_state = ioecfg_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n)
      if (!rst_n)
      begin
         state <= ioecfg_pkg::SEQ_IDLE;
         cur_exp <= 3'h0;
         step <= 3'h0;
         cmd <= '0;
         req_tgl <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cur_exp <= next_exp;
         step <= next_step;
         cmd <= next_cmd;
         req_tgl <= next_req;
      end

   // ----------------------------------------
   // link side, on the master bus clock
   // ----------------------------------------
   // cmd is held by the core until ack, so a plain capture is safe
   ioecfg_pkg::ioecfg_lnk_type lstate, next_lstate;
   ioecfg_pkg::ioecfg_cmd_type next_lcmd;
   logic [7:0] next_lrdata;
   logic next_ack;
   assign cmd_valid_out = lstate == ioecfg_pkg::LNK_ISSUE;
   always_comb
   begin
      next_lstate = lstate;
      next_lcmd = cmd_out;
      next_lrdata = lrdata;
      next_ack = ack_tgl;
      unique case (lstate)
         ioecfg_pkg::LNK_IDLE:
            if (req_edge)
            begin
               next_lcmd = cmd;
               next_lstate = ioecfg_pkg::LNK_ISSUE;
            end
         ioecfg_pkg::LNK_ISSUE:
            if (cmd_ready_in)
               next_lstate = ioecfg_pkg::LNK_WAIT;
         ioecfg_pkg::LNK_WAIT:
            if (rsp_done_in)
            begin
               next_lrdata = rsp_data_in;
               next_ack = ~ack_tgl;
               next_lstate = ioecfg_pkg::LNK_IDLE;
            end
         default: next_lstate = ioecfg_pkg::LNK_IDLE;
      endcase
   end

   always_ff @(posedge smb_clk_in or negedge lrst_n)
      if (!lrst_n)
      begin
         lstate <= ioecfg_pkg::LNK_IDLE;
         cmd_out <= '0;
         lrdata <= 8'h00;
         ack_tgl <= 1'b0;
      end
      else
      begin
         lstate <= next_lstate;
         cmd_out <= next_lcmd;
         lrdata <= next_lrdata;
         ack_tgl <= next_ack;
      end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_eeprom_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_IDLE && !ee_done |=> state == ioecfg_pkg::SEQ_IDLE)
      else $error("sequence started before eeprom done");
   a_first_trigger: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      wr_pend && wr_addr == ioecfg_pkg::OFS_ADDR_FIRST |=> pending[3:0] == 4'hf)
      else $error("address write did not request configuration");
   a_second_trigger: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      wr_pend && wr_addr == ioecfg_pkg::OFS_ADDR_SECOND |=> pending[4])
      else $error("second address write did not request configuration");
   a_pg_skip: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_WAIT && cur_exp == 3'h2 |-> cmd.reg_num != ioecfg_pkg::REG_OUT_HI)
      else $error("power-good expander got upper output write");
   a_inv_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_WAIT && cmd.reg_num[2:1] == 2'h2 |-> cmd.data == 8'h00)
      else $error("inversion register written non-zero");
   a_disabled_neg: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      $rose(state == ioecfg_pkg::SEQ_WAIT) && cur_exp == 3'h0 && cmd.reg_num == 3'h3
      && !$past(hp_cfg[4]) |-> cmd.data[7:4] == 4'h3)
      else $error("disabled port outputs not negated");
   a_step_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_WAIT && ack_edge && cur_exp == 3'h0
      && cmd.reg_num == ioecfg_pkg::REG_OUT_LO
      |=> ##1 state == ioecfg_pkg::SEQ_WAIT && cmd.reg_num == ioecfg_pkg::REG_OUT_HI)
      else $error("upper outputs did not follow lower outputs");
   a_serial_exp: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      state != ioecfg_pkg::SEQ_IDLE |=> $stable(cur_exp))
      else $error("expander changed inside a sequence");
   a_link_hold: assert property (@(posedge smb_clk_in) disable iff (!lrst_n)
      cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_out))
      else $error("command dropped before accept");
   c_hp_done: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_WAIT && cur_exp == 3'h0 && ack_edge && step == 3'h7);
   c_pg_read: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
      cap_we && cur_exp == 3'h2 && cmd.reg_num == ioecfg_pkg::REG_IN_LO);
   c_led_inv: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
      state == ioecfg_pkg::SEQ_WAIT && cur_exp == 3'h4
      && cmd.reg_num == ioecfg_pkg::REG_INV_LO);
endmodule // ioecfg_top
`default_nettype wire

/* logic/ioecfg_pkg.sv */
package ioecfg_pkg;
   localparam int unsigned NUM_EXP = 5;
   localparam int unsigned NUM_PORTS = 6;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] OFS_ADDR_FIRST = 8'h00;
   localparam logic [7:0] OFS_ADDR_SECOND = 8'h04;
   localparam logic [7:0] OFS_SLOT_CTL = 8'h08;
   localparam logic [7:0] OFS_HP_CFG = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CAPTURE = 8'h14;
   localparam logic [31:0] ADDR_FIELD_MASK = 32'h7f7f7f7f;
   localparam logic [31:0] ADDR_FIRST_RST = 32'h00000000;
   localparam logic [6:0] ADDR_SECOND_RST = 7'h00;
   // per port nibble: attn on, power ind on, power enable, interlock
   localparam logic [23:0] SLOT_CTL_RST = 24'h666666;
   localparam logic [5:0] HP_CFG_RST = 6'h3f;
   // ----------------------------------------
   // expander side
   // ----------------------------------------
   localparam logic [2:0] REG_IN_LO = 3'h0;
   localparam logic [2:0] REG_OUT_LO = 3'h2;
   localparam logic [2:0] REG_OUT_HI = 3'h3;
   localparam logic [2:0] REG_INV_LO = 3'h4;
   localparam int unsigned ATTN_BIT = 4;
   localparam int unsigned PIND_BIT = 5;
   localparam int unsigned PEN_BIT = 6;
   localparam int unsigned ILOCK_BIT = 7;
   localparam logic [7:0] DIR_HOTPLUG = 8'h0f;
   localparam logic [7:0] DIR_ALL_IN = 8'hff;
   localparam logic [7:0] DIR_ALL_OUT = 8'h00;
   localparam logic [7:0] INV_NONE = 8'h00;
   localparam logic [7:0] LED_UNUSED = 8'hc0;
   localparam logic [2:0] LAST_STEP = 3'h7;
   typedef struct packed {
      logic [6:0] addr;
      logic rd;
      logic [2:0] reg_num;
      logic [7:0] data;
   } ioecfg_cmd_type;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} ioecfg_seq_type;
   typedef enum logic [1:0] {LNK_IDLE, LNK_ISSUE, LNK_WAIT} ioecfg_lnk_type;
endpackage

/* tb/ioecfg_exp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ioecfg_exp_model (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic cmd_valid_in,
   input wire ioecfg_pkg::ioecfg_cmd_type cmd_in,
   output logic cmd_ready_out,
   output logic rsp_done_out,
   output logic [7:0] rsp_data_out
);
   // ----------------------------------------
   // expander register file and pins
   // ----------------------------------------
   logic [7:0] mem [0:127][0:7];
   logic [7:0] rd_val;
   logic busy;
   int cnt;

   // input byte: output latch where driven, fixed pin pattern where input
   function automatic logic [7:0] pin_val(input logic [6:0] a, input logic [2:0] r);
      logic [7:0] o;
      logic [7:0] d;
      o = mem[a][r + 3'h2];
      d = mem[a][r + 3'h6];
      return (o & ~d) | (({1'b0, a} ^ (r[0] ? 8'ha5 : 8'h5a)) & d);
   endfunction

   always @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
      begin
         cmd_ready_out <= 1'b0;
         rsp_done_out <= 1'b0;
         rsp_data_out <= 8'h00;
         busy <= 1'b0;
         cnt <= 0;
      end
      else
      begin
         rsp_done_out <= 1'b0;
         // data line is meaningless outside the done pulse
         rsp_data_out <= ~rsp_data_out;
         if (cmd_valid_in && cmd_ready_out)
         begin
            cmd_ready_out <= 1'b0;
            busy <= 1'b1;
            cnt <= $urandom_range(4, 1);
            if (cmd_in.rd)
               rd_val <= pin_val(cmd_in.addr, cmd_in.reg_num);
            else
               mem[cmd_in.addr][cmd_in.reg_num] <= cmd_in.data;
         end
         else if (busy)
         begin
            cnt <= cnt - 1;
            if (cnt == 1)
            begin
               busy <= 1'b0;
               rsp_done_out <= 1'b1;
               rsp_data_out <= rd_val;
            end
         end
         else if (cmd_valid_in)
            cmd_ready_out <= ($urandom_range(2, 0) == 0);
      end
endmodule // ioecfg_exp_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
   logic ref_clk = 1'b0;
   logic smb_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic eed = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [5:0] link_up = 6'h00;
   logic [5:0] link_act = 6'h00;
   wire logic hrdyo;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic cmd_valid;
   wire logic cmd_ready;
   wire logic rsp_done;
   wire logic [7:0] rsp_data;
   wire ioecfg_pkg::ioecfg_cmd_type cmd;
   ioecfg_pkg::ioecfg_cmd_type exp_q[$];
   ioecfg_pkg::ioecfg_cmd_type ec;
   int fail_count = 0;
   int check_count = 0;
   logic [23:0] slot = 24'h666666;
   logic [5:0] hpc = 6'h3f;
   logic [6:0] ea [0:4];
   logic [15:0] cap [0:3];

   always #20 ref_clk = ~ref_clk;
   // link clock deliberately offset from the core clock
   initial
   begin
      #7;
      forever #40 smb_clk = ~smb_clk;
   end

   ioecfg_top i_ioecfg_top (.ref_clk_in(ref_clk), .arst_n_in(rst_n), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdyo), .hreadyout_out(hrdyo), .hresp_out(hresp),
      .hrdata_out(hrdata), .link_up_in(link_up), .link_act_in(link_act),
      .smb_clk_in(smb_clk), .eeprom_done_in(eed), .cmd_valid_out(cmd_valid),
      .cmd_out(cmd), .cmd_ready_in(cmd_ready), .rsp_done_in(rsp_done),
      .rsp_data_in(rsp_data));
   ioecfg_exp_model i_ioecfg_exp_model (.clk_in(smb_clk), .arst_n_in(rst_n),
      .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
      .rsp_done_out(rsp_done), .rsp_data_out(rsp_data));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize();
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // read data taken at the same edge that finds ready high
   task automatic take(output logic [31:0] d);
      for (int n = 0; n < 50; n++)
      begin
         @(posedge ref_clk);
         d = hrdata;
         if (hrdyo === 1'b1)
            return;
      end
      fail_count++;
      summarize();
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      take(d);
      htrans <= 2'h0;
      hwdata <= wd;
      take(d);
   endtask

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rdchk(input logic [31:0] a, e, m);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      `CHK("hrdata", e & m, d & m)
      `CHK("hresp", 1'b0, hresp)
   endtask

   function automatic logic [7:0] hp(input int p);
      return hpc[p] ? {slot[4*p+3], slot[4*p+2], ~slot[4*p+1], ~slot[4*p], 4'h0} : 8'h30;
   endfunction

   function automatic logic [7:0] pin(input logic [6:0] a, input logic [7:0] o, d,
         input bit hi);
      return (o & ~d) | (({1'b0, a} ^ (hi ? 8'ha5 : 8'h5a)) & d);
   endfunction

   task automatic pw(input int e, input logic [2:0] r, input logic [7:0] v);
      exp_q.push_back({ea[e], 1'b0, r, v});
   endtask

   task automatic push_seq(input int e);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] dl;
      logic [7:0] dh;
      lo = (e == 0) ? hp(2) : (e == 1) ? hp(3) : 8'h00;
      hi = (e == 0) ? hp(4) : (e == 1) ? hp(5) : hp(1);
      dl = (e < 2) ? 8'h0f : 8'hff;
      dh = (e == 2) ? 8'hff : 8'h0f;
      if (e == 4)
      begin
         lo = {2'b11, ~(hpc & link_up)};
         hi = {2'b11, ~(hpc & link_act)};
         dl = 8'h00;
         dh = 8'h00;
      end
      pw(e, 3'h2, lo);
      if (e != 2)
         pw(e, 3'h3, hi);
      pw(e, 3'h4, 8'h00);
      pw(e, 3'h5, 8'h00);
      pw(e, 3'h6, dl);
      pw(e, 3'h7, dh);
      if (e != 4)
      begin
         exp_q.push_back({ea[e], 1'b1, 3'h0, 8'h00});
         exp_q.push_back({ea[e], 1'b1, 3'h1, 8'h00});
         cap[e] = {pin(ea[e], hi, dh, 1'b1), pin(ea[e], lo, dl, 1'b0)};
      end
   endtask

   task automatic drain();
      for (int n = 0; n < 20000 && exp_q.size() > 0; n++)
         @(posedge ref_clk);
      if (exp_q.size() > 0)
      begin
         fail_count++;
         summarize();
      end
      repeat (40) @(posedge ref_clk);
      rdchk(32'(ioecfg_pkg::OFS_STATUS), 32'h2, 32'h1f03);
   endtask

   // every accepted command is matched against the oldest expectation
   always @(posedge smb_clk)
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            fail_count++;
            $display("[FAIL] cmd exp none got %h", cmd);
         end
         else
         begin
            ec = exp_q.pop_front();
            `CHK("cmd", {ec[18:8], ec.rd ? 8'h00 : ec.data}, {cmd[18:8], cmd.rd ? 8'h00 : cmd.data})
         end
      end

   initial
   begin
      void'($urandom(31667));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdchk(32'(ioecfg_pkg::OFS_SLOT_CTL), 32'h666666, 32'hffffffff);
      // a byte-sized write must be dropped
      hsize <= 3'h0;
      wr(32'(ioecfg_pkg::OFS_HP_CFG), 32'h0);
      hsize <= 3'h2;
      rdchk(32'(ioecfg_pkg::OFS_HP_CFG), 32'h3f, 32'hffffffff);
      rdchk(32'h40, 32'h0, 32'hffffffff);
      ea[4] = 7'($urandom);
      link_up <= 6'($urandom);
      link_act <= 6'($urandom);
      wr(32'(ioecfg_pkg::OFS_ADDR_SECOND), {25'h0, ea[4]});
      // bus still owned by the loader: nothing may be issued
      repeat (200) @(posedge ref_clk);
      rdchk(32'(ioecfg_pkg::OFS_STATUS), 32'h1000, 32'h1f02);
      eed <= 1'b1;
      push_seq(4);
      drain();
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
         begin
            slot = 24'($urandom);
            hpc = 6'($urandom);
            wr(32'(ioecfg_pkg::OFS_SLOT_CTL), {8'h0, slot});
            wr(32'(ioecfg_pkg::OFS_HP_CFG), {26'h0, hpc});
         end
         ea[0] = 7'($urandom);
         for (int e = 1; e < 4; e++)
            ea[e] = ea[0] + 7'(17 * e);
         for (int e = 0; e < 4; e++)
            push_seq(e);
         wr(32'(ioecfg_pkg::OFS_ADDR_FIRST), {1'b1, ea[3], 1'b1, ea[2], 1'b1, ea[1], 1'b1, ea[0]});
         rdchk(32'(ioecfg_pkg::OFS_ADDR_FIRST), {1'b0, ea[3], 1'b0, ea[2], 1'b0, ea[1], 1'b0, ea[0]},
            32'hffffffff);
         drain();
         for (int e = 0; e < 4; e++)
            rdchk(32'(ioecfg_pkg::OFS_CAPTURE) + 32'(4 * e), {16'h0, cap[e]}, 32'hffffffff);
      end
      summarize();
   end
endmodule // tb_top
`default_nettype wire
